// [verilog/cpac_consts.svh]
/*
  Shared constants of the cache partition allocation control: geometry, register offsets,
  field positions and reset values.
  Assumes inclusion by its bare name from the package and from every design module.
*/
`ifndef CPAC_CONSTS_SVH
`define CPAC_CONSTS_SVH
// Functional notes
// - Partition id arrives with each request and resource controls exist, so cache is partitionable.
// - Feature id register shows one present bit per implemented control.
// - Software selects partition first, then writes a control; write lands on selection.
// - Storage is split into a fixed number of equal portions shared by grantees.
// - Installing a line only considers portions the partition may allocate into.
// - Portion map has one bit per portion; width equals advertised portion count.
// - Changing a portion map affects later allocations only; resident lines stay.
// - Grants are whole portions; any portion may be private or shared.
// - A partition at its capacity limit cannot grow its occupancy further.
// - At the limit, replace own data or skip allocation.
// - Lookups hit any valid line whatever partition allocated it.
// - Capacity limit is an unsigned fraction of total capacity; all ones means one.
// - Only upper fraction bits are kept; written value is truncated.
// - Unkept low fraction bits are used as zero.
// - Enforced capacity lies between stored setting and setting plus one kept lsb.
// - Portion map and capacity limit both apply to every allocation.
// - All requests of one partition id use that partition's single setting set.
`define CPAC_PID_W        4
`define CPAC_NUM_PID      16
`define CPAC_WAYS         8
`define CPAC_WAY_W        3
`define CPAC_IDX_W        4
`define CPAC_SETS         16
`define CPAC_TAG_W        20
`define CPAC_LINES        (`CPAC_WAYS * `CPAC_SETS)
`define CPAC_OCC_W        8
`define CPAC_FRAC_W       16
`define CPAC_FRAC_IMPL    8
`define CPAC_FRAC_ONE     16'hFFFF
`define CPAC_MAP_RST      8'hFF
`define CPAC_ADDR_W       12
`define CPAC_OFS_FEATURE  12'h000
`define CPAC_OFS_PCOUNT   12'h004
`define CPAC_OFS_SELECT   12'h008
`define CPAC_OFS_MAP      12'h00C
`define CPAC_OFS_CAPLIM   12'h010
`define CPAC_OFS_OCC      12'h014
`define CPAC_OFS_PIDMAX   12'h018
`define CPAC_FEAT_PORTION 0
`define CPAC_FEAT_CAPLIM  1
`endif

// [verilog/cpac_pkg.sv]
/*
  Types of the cache partition allocation control.
  Assumes the constants header is on the include path.
*/
`include "cpac_consts.svh"
package cpac_pkg;
    typedef struct packed {
        logic                    valid;
        logic                    inval;
        logic                    alloc;
        logic [`CPAC_PID_W-1:0]  pid;
        logic [`CPAC_IDX_W-1:0]  idx;
        logic [`CPAC_TAG_W-1:0]  tag;
    } cpac_req_t;
    typedef struct packed {
        logic                    valid;
        logic                    hit;
        logic                    alloc;
        logic [`CPAC_WAY_W-1:0]  way;
        logic                    evicted;
        logic [`CPAC_PID_W-1:0]  evict_pid;
    } cpac_resp_t;
    typedef struct packed {
        logic                    sel_we;
        logic                    map_we;
        logic                    cap_we;
        logic [31:0]             wdata;
    } cpac_cfg_wr_t;
    typedef struct packed {
        logic [`CPAC_PID_W-1:0]  sel;
        logic [`CPAC_WAYS-1:0]   map;
        logic [`CPAC_FRAC_W-1:0] cap;
        logic [`CPAC_OCC_W-1:0]  occ;
    } cpac_cfg_rd_t;
endpackage : cpac_pkg

// [verilog/cpac_apb.sv]
/*
  APB slave of the cache partition allocation control: decode, read data, write strobes.
  Assumes APB on the block clock; zero wait states; the owner applies strobes at the access edge.
*/
`timescale 1ns/1ps
`include "cpac_consts.svh"
module cpac_apb
    import cpac_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    // APB
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [`CPAC_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic [31:0]                  o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    // Register file side
    output cpac_cfg_wr_t                 o_wr,
    input  cpac_cfg_rd_t                 i_rd
);
    function automatic logic is_reg(input logic [`CPAC_ADDR_W-1:0] a, input logic [`CPAC_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : is_reg

    logic [31:0] rdata;
    logic        known;
    logic        access;

    always_comb begin
        rdata = 32'h0000_0000;
        known = 1'b1;
        unique case (i_paddr)
            `CPAC_OFS_FEATURE: begin
                rdata[`CPAC_FEAT_PORTION] = 1'b1;
                rdata[`CPAC_FEAT_CAPLIM]  = 1'b1;
            end
            `CPAC_OFS_PCOUNT: rdata = 32'(`CPAC_WAYS);
            `CPAC_OFS_SELECT: rdata = 32'(i_rd.sel);
            `CPAC_OFS_MAP:    rdata = 32'(i_rd.map);
            `CPAC_OFS_CAPLIM: rdata = 32'(i_rd.cap);
            `CPAC_OFS_OCC:    rdata = 32'(i_rd.occ);
            `CPAC_OFS_PIDMAX: rdata = 32'(`CPAC_NUM_PID - 1);
            default:          known = 1'b0;
        endcase
    end

    // Answer is prepared in the setup cycle and held through the access phase
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_psel && !i_penable) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata;
            o_pslverr <= !known;
        end
    end

    assign o_pready = 1'b1;
    assign access   = i_psel && i_penable && i_pwrite;
    assign o_wr.sel_we = access && is_reg(i_paddr, `CPAC_OFS_SELECT);
    assign o_wr.map_we = access && is_reg(i_paddr, `CPAC_OFS_MAP);
    assign o_wr.cap_we = access && is_reg(i_paddr, `CPAC_OFS_CAPLIM);
    assign o_wr.wdata  = i_pwdata;
endmodule : cpac_apb

// [verilog/cpac_victim.sv]
/*
  Victim choice of the cache partition allocation control.
  Purely combinational; assumes the portion count is a power of two so way indices wrap.
*/
`timescale 1ns/1ps
`include "cpac_consts.svh"
module cpac_victim
    import cpac_pkg::*;
(
    // State of the addressed set
    input  wire logic [`CPAC_WAYS-1:0]  i_allow,
    input  wire logic [`CPAC_WAYS-1:0]  i_valid,
    input  wire logic [`CPAC_WAYS-1:0]  i_own,
    input  wire logic                   i_full,
    input  wire logic [`CPAC_WAY_W-1:0] i_start,
    // Choice
    output logic                        o_alloc,
    output logic [`CPAC_WAY_W-1:0]      o_way
);
    // First set bit at or after the start way; top bit flags success
    function automatic logic [`CPAC_WAY_W:0] pick(input logic [`CPAC_WAYS-1:0] m,
                                                 input logic [`CPAC_WAY_W-1:0] s);
        logic [`CPAC_WAY_W:0]   r;
        logic [`CPAC_WAY_W-1:0] k;
        r = '0;
        for (int i = `CPAC_WAYS - 1; i >= 0; i--) begin
            k = s + `CPAC_WAY_W'(i);
            if (m[k]) begin
                r = {1'b1, k};
            end
        end
        return r;
    endfunction : pick

    logic [`CPAC_WAY_W:0] free_w;
    logic [`CPAC_WAY_W:0] any_w;
    logic [`CPAC_WAY_W:0] own_w;
    logic [`CPAC_WAY_W:0] res;

    always_comb begin
        free_w = pick(i_allow & ~i_valid, i_start);
        any_w  = pick(i_allow, i_start);
        own_w  = pick(i_allow & i_own, i_start);
        if (i_full) begin
            res = own_w;
        end else if (free_w[`CPAC_WAY_W]) begin
            res = free_w;
        end else begin
            res = any_w;
        end
    end

    assign o_alloc = res[`CPAC_WAY_W];
    assign o_way   = res[`CPAC_WAY_W-1:0];
endmodule : cpac_victim

// [verilog/cpac_top.sv]
/*
  Cache partition allocation control: tag store with per-partition portion maps,
  capacity limits and occupancy counters, configured over APB.
  Assumes requests and APB come from logic on I_CLK; one request is taken per cycle.
*/
`timescale 1ns/1ps
`include "cpac_consts.svh"
module cpac_top
    import cpac_pkg::*;
(
    // Clock and reset
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET,
    // Requests from upstream
    input  cpac_req_t                    I_REQ,
    output cpac_resp_t                   O_RESP,
    // APB
    input  wire logic                    I_PSEL,
    input  wire logic                    I_PENABLE,
    input  wire logic                    I_PWRITE,
    input  wire logic [`CPAC_ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]             I_PWDATA,
    output logic [31:0]                  O_PRDATA,
    output logic                         O_PREADY,
    output logic                         O_PSLVERR
);
    // Lines that a stored fraction grants, rounded up to whole lines
    function automatic logic [`CPAC_OCC_W-1:0] cap_lines(input logic [`CPAC_FRAC_IMPL-1:0] f);
        logic [31:0] full_frac;
        logic [31:0] prod;
        full_frac = 32'({f, (`CPAC_FRAC_W - `CPAC_FRAC_IMPL)'(0)});
        prod      = full_frac * 32'(`CPAC_LINES) + 32'(`CPAC_FRAC_ONE);
        return prod[`CPAC_FRAC_W +: `CPAC_OCC_W];
    endfunction : cap_lines

    // Tag store
    logic [`CPAC_TAG_W-1:0]    tag_q   [`CPAC_SETS][`CPAC_WAYS];
    logic [`CPAC_PID_W-1:0]    owner_q [`CPAC_SETS][`CPAC_WAYS];
    logic [`CPAC_WAYS-1:0]     vld_q   [`CPAC_SETS];

    // Per-partition settings and accounting
    logic [`CPAC_WAYS-1:0]      map_q [`CPAC_NUM_PID];
    logic [`CPAC_FRAC_IMPL-1:0] cap_q [`CPAC_NUM_PID];
    logic [`CPAC_OCC_W-1:0]     occ_q [`CPAC_NUM_PID];
    logic [`CPAC_PID_W-1:0]     sel_q;
    logic [`CPAC_WAY_W-1:0]     rr_q;
    cpac_resp_t                 resp_q;
    cpac_resp_t                 resp_d;

    // Request view
    cpac_cfg_wr_t               cfg_wr;
    cpac_cfg_rd_t               cfg_rd;
    logic [`CPAC_WAYS-1:0]      set_vld;
    logic [`CPAC_WAYS-1:0]      hit_vec;
    logic [`CPAC_WAYS-1:0]      own_vec;
    logic                       hit;
    logic [`CPAC_WAY_W-1:0]     hit_way;
    logic [`CPAC_WAYS-1:0]      allow;
    logic [`CPAC_OCC_W-1:0]     limit;
    logic                       full;
    logic                       vic_alloc;
    logic [`CPAC_WAY_W-1:0]     vic_way;

    // Install and removal decisions
    logic                       do_fill;
    logic                       do_inval;
    logic [`CPAC_WAY_W-1:0]     fill_way;
    logic                       displaced;
    logic [`CPAC_PID_W-1:0]     displaced_pid;
    logic                       inc_en;
    logic                       dec_en;
    logic [`CPAC_PID_W-1:0]     dec_pid;

    cpac_apb u_apb (
        .i_clk     (I_CLK),
        .i_reset   (I_RESET),
        .i_psel    (I_PSEL),
        .i_penable (I_PENABLE),
        .i_pwrite  (I_PWRITE),
        .i_paddr   (I_PADDR),
        .i_pwdata  (I_PWDATA),
        .o_prdata  (O_PRDATA),
        .o_pready  (O_PREADY),
        .o_pslverr (O_PSLVERR),
        .o_wr      (cfg_wr),
        .i_rd      (cfg_rd)
    );

    // Read-back of the selected partition
    always_comb begin
        cfg_rd.sel = sel_q;
        cfg_rd.map = map_q[sel_q];
        cfg_rd.cap = {cap_q[sel_q], (`CPAC_FRAC_W - `CPAC_FRAC_IMPL)'(0)};
        cfg_rd.occ = occ_q[sel_q];
    end

    // Partition select
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            sel_q <= '0;
        end else if (cfg_wr.sel_we) begin
            sel_q <= cfg_wr.wdata[`CPAC_PID_W-1:0];
        end
    end

    // Per-partition controls; a new map touches no resident line
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            for (int p = 0; p < `CPAC_NUM_PID; p++) begin
                map_q[p] <= `CPAC_MAP_RST;
                cap_q[p] <= `CPAC_FRAC_IMPL'(`CPAC_FRAC_ONE >> (`CPAC_FRAC_W - `CPAC_FRAC_IMPL));
            end
        end else begin
            if (cfg_wr.map_we) begin
                map_q[sel_q] <= cfg_wr.wdata[`CPAC_WAYS-1:0];
            end
            if (cfg_wr.cap_we) begin
                cap_q[sel_q] <= cfg_wr.wdata[`CPAC_FRAC_W-1 -: `CPAC_FRAC_IMPL];
            end
        end
    end

    // Lookup over all partitions
    always_comb begin
        set_vld = vld_q[I_REQ.idx];
        hit_way = '0;
        for (int w = 0; w < `CPAC_WAYS; w++) begin
            hit_vec[w] = set_vld[w] && (tag_q[I_REQ.idx][w] == I_REQ.tag);
            own_vec[w] = set_vld[w] && (owner_q[I_REQ.idx][w] == I_REQ.pid);
        end
        for (int w = `CPAC_WAYS - 1; w >= 0; w--) begin
            if (hit_vec[w]) begin
                hit_way = `CPAC_WAY_W'(w);
            end
        end
        hit = |hit_vec;
    end

    // Settings of the requesting partition
    always_comb begin
        allow = map_q[I_REQ.pid];
        limit = cap_lines(cap_q[I_REQ.pid]);
        full  = occ_q[I_REQ.pid] >= limit;
    end

    cpac_victim u_victim (
        .i_allow (allow),
        .i_valid (set_vld),
        .i_own   (own_vec),
        .i_full  (full),
        .i_start (rr_q),
        .o_alloc (vic_alloc),
        .o_way   (vic_way)
    );

    // Install on an allocating miss, removal on an invalidate hit
    always_comb begin
        do_fill  = I_REQ.valid && !I_REQ.inval && I_REQ.alloc && !hit && vic_alloc;
        do_inval = I_REQ.valid && I_REQ.inval && hit;
        fill_way = do_inval ? hit_way : vic_way;
        displaced     = 1'b0;
        displaced_pid = owner_q[I_REQ.idx][fill_way];
        if (do_fill) begin
            displaced = set_vld[fill_way];
        end else if (do_inval) begin
            displaced = 1'b1;
        end
    end

    // Occupancy moves: a replaced own line leaves the count unchanged
    always_comb begin
        inc_en  = do_fill && !(displaced && displaced_pid == I_REQ.pid);
        dec_en  = displaced && !(do_fill && displaced_pid == I_REQ.pid);
        dec_pid = displaced_pid;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            for (int p = 0; p < `CPAC_NUM_PID; p++) begin
                occ_q[p] <= '0;
            end
        end else begin
            for (int p = 0; p < `CPAC_NUM_PID; p++) begin
                if (inc_en && !dec_en && I_REQ.pid == `CPAC_PID_W'(p)) begin
                    occ_q[p] <= occ_q[p] + `CPAC_OCC_W'(1);
                end else if (dec_en && !inc_en && dec_pid == `CPAC_PID_W'(p)) begin
                    occ_q[p] <= occ_q[p] - `CPAC_OCC_W'(1);
                end else if (inc_en && dec_en) begin
                    if (I_REQ.pid == `CPAC_PID_W'(p)) begin
                        occ_q[p] <= occ_q[p] + `CPAC_OCC_W'(1);
                    end else if (dec_pid == `CPAC_PID_W'(p)) begin
                        occ_q[p] <= occ_q[p] - `CPAC_OCC_W'(1);
                    end
                end
            end
        end
    end

    // Valid bits
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            for (int s = 0; s < `CPAC_SETS; s++) begin
                vld_q[s] <= '0;
            end
        end else if (do_fill) begin
            vld_q[I_REQ.idx][fill_way] <= 1'b1;
        end else if (do_inval) begin
            vld_q[I_REQ.idx][fill_way] <= 1'b0;
        end
    end

    // Tag and owner of an installed line; data path, no reset needed
    always_ff @(posedge I_CLK) begin
        if (do_fill) begin
            tag_q[I_REQ.idx][fill_way]   <= I_REQ.tag;
            owner_q[I_REQ.idx][fill_way] <= I_REQ.pid;
        end
    end

    // Rotating start point spreads fills over the permitted portions
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rr_q <= '0;
        end else if (do_fill) begin
            rr_q <= fill_way + `CPAC_WAY_W'(1);
        end
    end

    // Answer one cycle after the request
    always_comb begin
        resp_d           = '0;
        resp_d.valid     = I_REQ.valid;
        resp_d.hit       = I_REQ.valid && hit;
        resp_d.alloc     = do_fill;
        resp_d.way       = hit ? hit_way : (do_fill ? vic_way : '0);
        resp_d.evicted   = displaced;
        resp_d.evict_pid = displaced ? displaced_pid : '0;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            resp_q <= '0;
        end else begin
            resp_q <= resp_d;
        end
    end

    assign O_RESP = resp_q;
endmodule : cpac_top

// [verification/cpac_properties.sv]
/*
  Concurrent checks on the ports of the cache partition allocation control.
  Assumes binding into cpac_top; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "cpac_consts.svh"
module cpac_properties
    import cpac_pkg::*;
(
    // Clock and reset
    input  wire logic                    I_CLK,
    input  wire logic                    I_RESET,
    // Requests
    input  cpac_req_t                    I_REQ,
    input  cpac_resp_t                   O_RESP,
    // APB
    input  wire logic                    I_PSEL,
    input  wire logic                    I_PENABLE,
    input  wire logic                    I_PWRITE,
    input  wire logic [`CPAC_ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]             I_PWDATA,
    input  wire logic [31:0]             O_PRDATA,
    input  wire logic                    O_PREADY,
    input  wire logic                    O_PSLVERR
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_rd(logic [`CPAC_ADDR_W-1:0] a);
        s_setup ##0 (!I_PWRITE && I_PADDR == a);
    endsequence

    a_resp_follows: assert property (I_REQ.valid |=> O_RESP.valid)
        else $error("request without response");
    a_resp_idle: assert property (!I_REQ.valid |=> !O_RESP.valid)
        else $error("response without request");
    a_hit_no_fill: assert property (O_RESP.valid && O_RESP.hit |-> !O_RESP.alloc)
        else $error("fill on a hit");
    a_fill_cause: assert property (O_RESP.valid && O_RESP.alloc |-> !O_RESP.hit && $past(I_REQ.alloc && !I_REQ.inval))
        else $error("fill without allocating miss");
    a_evict_cause: assert property (O_RESP.valid && O_RESP.evicted |-> O_RESP.alloc || $past(I_REQ.inval))
        else $error("line removed without fill or invalidate");
    a_inval_evicts: assert property (O_RESP.valid && O_RESP.hit && $past(I_REQ.inval) |-> O_RESP.evicted)
        else $error("invalidate hit kept the line");
    a_ready_high: assert property (O_PREADY)
        else $error("ready low");
    a_err_unmapped: assert property (s_setup |=> O_PSLVERR ==
        ($past(I_PADDR) > `CPAC_OFS_PIDMAX || $past(I_PADDR[1:0]) != 2'b00))
        else $error("error flag wrong for address");
    a_feature_id: assert property (s_rd(`CPAC_OFS_FEATURE) |=> O_PRDATA == 32'h3)
        else $error("feature id wrong");
    a_portion_count: assert property (s_rd(`CPAC_OFS_PCOUNT) |=> O_PRDATA == 32'(`CPAC_WAYS))
        else $error("portion count wrong");
    a_cap_trunc: assert property (s_rd(`CPAC_OFS_CAPLIM) |=> O_PRDATA[7:0] == 8'h00)
        else $error("capacity low bits not zero");
endmodule : cpac_properties

bind cpac_top cpac_properties u_cpac_properties (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_REQ(I_REQ), .O_RESP(O_RESP), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR)
);

// [verification/cpac_requester.sv]
/*
  Upstream requester and configuring software for the allocation control.
  Assumes the bench calls its tasks one at a time from a single process.
*/
`timescale 1ns/1ps
`include "cpac_consts.svh"
module cpac_requester
    import cpac_pkg::*;
(
    // Clock
    input  wire logic                    i_clk,
    // Request port
    output cpac_req_t                    o_req,
    input  cpac_resp_t                   i_resp,
    // APB master
    output logic                         o_psel,
    output logic                         o_penable,
    output logic                         o_pwrite,
    output logic [`CPAC_ADDR_W-1:0]      o_paddr,
    output logic [31:0]                  o_pwdata,
    input  wire logic [31:0]             i_prdata,
    input  wire logic                    i_pready,
    input  wire logic                    i_pslverr
);
    initial begin
        o_req = '0;
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = '0;
        o_pwdata = '0;
    end

    task automatic access(input logic [3:0] p, i, input logic [19:0] t, input logic al, iv,
                          output cpac_resp_t r);
        @(posedge i_clk);
        o_req <= '{valid: 1'b1, inval: iv, alloc: al, pid: p, idx: i, tag: t};
        @(posedge i_clk);
        o_req <= {1'b0, ~o_req[29:0]};
        #1 r = i_resp;
    endtask : access

    task automatic apb(input logic wr, input logic [`CPAC_ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= wr;
        o_paddr   <= a;
        o_pwdata  <= wd;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do @(posedge i_clk); while (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        o_paddr   <= ~a;
        o_pwdata  <= ~wd;
    endtask : apb

    // Select first, then the controls; never interleaved
    task automatic cfg(input logic [3:0] p, input logic [7:0] m, input logic [15:0] c);
        logic [31:0] d;
        logic        e;
        apb(1'b1, `CPAC_OFS_SELECT, 32'(p), d, e);
        apb(1'b1, `CPAC_OFS_MAP, 32'(m), d, e);
        apb(1'b1, `CPAC_OFS_CAPLIM, 32'(c), d, e);
    endtask : cfg
endmodule : cpac_requester

// [verification/tb.sv]
/*
  Self-checking bench of the cache partition allocation control.
  Assumes the requester model drives all design inputs except clock and reset.
*/
`timescale 1ns/1ps
`include "cpac_consts.svh"
module tb;
    import cpac_pkg::*;
    logic                    clk;
    logic                    rst;
    cpac_req_t               req;
    cpac_resp_t              resp;
    cpac_resp_t              rs;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [`CPAC_ADDR_W-1:0] paddr;
    logic [31:0]             pwdata;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             d;
    logic                    e;
    int                      fails = 0;
    int                      tests_run = 0;
    int                      cyc = 0;

    cpac_top u_cpac_top (.I_CLK(clk), .I_RESET(rst), .I_REQ(req), .O_RESP(resp), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
    cpac_requester u_cpac_requester (.i_clk(clk), .o_req(req), .i_resp(resp), .o_psel(psel),
        .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
        .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", n, exp, got);
        end
    endtask : chk

    function automatic logic [31:0] pk(input logic h, a, input logic [2:0] w, input logic v,
                                       input logic [3:0] p);
        return 32'({h, a, w, v, p});
    endfunction : pk

    // Packed view of the last response taken by acc
    function automatic logic [31:0] seen();
        return pk(rs.hit, rs.alloc, rs.way, rs.evicted, rs.evict_pid);
    endfunction : seen

    task automatic acc(input logic [3:0] p, i, input logic [19:0] t, input logic al, iv);
        u_cpac_requester.access(p, i, t, al, iv, rs);
    endtask : acc

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string n);
        u_cpac_requester.apb(1'b0, a, 32'h0, d, e);
        chk(n, d, exp);
    endtask : rd

    task automatic occ(input logic [3:0] p, input logic [31:0] exp);
        u_cpac_requester.apb(1'b1, `CPAC_OFS_SELECT, 32'(p), d, e);
        rd(`CPAC_OFS_OCC, exp, "occupancy");
    endtask : occ

    initial begin
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(`CPAC_OFS_FEATURE, 32'h3, "feature");
        rd(`CPAC_OFS_PCOUNT, 32'h8, "portions");
        rd(`CPAC_OFS_PIDMAX, 32'hF, "pid max");
        rd(`CPAC_OFS_MAP, 32'hFF, "map reset");
        rd(`CPAC_OFS_CAPLIM, 32'hFF00, "cap reset");
        u_cpac_requester.apb(1'b1, `CPAC_OFS_FEATURE, 32'h0, d, e);
        rd(`CPAC_OFS_FEATURE, 32'h3, "read-only");
        u_cpac_requester.apb(1'b0, 12'h01C, 32'h0, d, e);
        chk("unmapped", 32'(e), 32'h1);
        // Two ways granted, then shared with a second partition
        u_cpac_requester.cfg(4'h1, 8'h0C, 16'hFF00);
        acc(4'h1, 4'h0, 20'h1, 1'b1, 1'b0);
        chk("fill1", seen(), pk(1'b0, 1'b1, 3'h2, 1'b0, 4'h0));
        acc(4'h1, 4'h0, 20'h2, 1'b1, 1'b0);
        chk("fill2", seen(), pk(1'b0, 1'b1, 3'h3, 1'b0, 4'h0));
        occ(4'h1, 32'h2);
        acc(4'h5, 4'h0, 20'h2, 1'b0, 1'b0);
        chk("foreign hit", seen(), pk(1'b1, 1'b0, 3'h3, 1'b0, 4'h0));
        u_cpac_requester.cfg(4'h5, 8'h0C, 16'hFF00);
        acc(4'h5, 4'h0, 20'h3, 1'b1, 1'b0);
        chk("shared", seen(), pk(1'b0, 1'b1, 3'h2, 1'b1, 4'h1));
        occ(4'h1, 32'h1);
        occ(4'h5, 32'h1);
        // Narrowed map keeps resident lines
        u_cpac_requester.cfg(4'h1, 8'h01, 16'hFF00);
        acc(4'h1, 4'h0, 20'h2, 1'b1, 1'b0);
        chk("resident", seen(), pk(1'b1, 1'b0, 3'h3, 1'b0, 4'h0));
        acc(4'h1, 4'h0, 20'h4, 1'b1, 1'b0);
        chk("new map", seen(), pk(1'b0, 1'b1, 3'h0, 1'b0, 4'h0));
        acc(4'h1, 4'h0, 20'h4, 1'b0, 1'b1);
        chk("invalidate", seen(), pk(1'b1, 1'b0, 3'h0, 1'b1, 4'h1));
        occ(4'h1, 32'h1);
        // Limits from truncated settings: one line, zero lines, whole capacity
        u_cpac_requester.cfg(4'h3, 8'hFF, 16'h02FF);
        rd(`CPAC_OFS_CAPLIM, 32'h0200, "cap trunc");
        acc(4'h3, 4'h1, 20'hA, 1'b1, 1'b0);
        chk("limit fill", 32'(rs.alloc), 32'h1);
        acc(4'h3, 4'h2, 20'hB, 1'b1, 1'b0);
        chk("limit skip", seen(), pk(1'b0, 1'b0, 3'h0, 1'b0, 4'h0));
        acc(4'h3, 4'h1, 20'hC, 1'b1, 1'b0);
        chk("own replace", 32'({rs.alloc, rs.evicted, rs.evict_pid}), 32'h33);
        occ(4'h3, 32'h1);
        u_cpac_requester.cfg(4'h4, 8'hFF, 16'h00FF);
        acc(4'h4, 4'h3, 20'h14, 1'b1, 1'b0);
        chk("zero limit", seen(), pk(1'b0, 1'b0, 3'h0, 1'b0, 4'h0));
        u_cpac_requester.cfg(4'h6, 8'h10, 16'hFFFF);
        rd(`CPAC_OFS_CAPLIM, 32'hFF00, "cap one");
        acc(4'h6, 4'h4, 20'h1E, 1'b1, 1'b0);
        chk("both", seen(), pk(1'b0, 1'b1, 3'h4, 1'b0, 4'h0));
        rd(`CPAC_OFS_MAP, 32'h10, "map sel6");
        rd(`CPAC_OFS_SELECT, 32'h6, "select");
        close_out();
    end
endmodule : tb
